//--- common/nvmsda_pkg.sv
// Purpose: Shared constants and types for the nonvolatile status, data and address registers
// Assumes: AXI4-Lite register access, byte address = 4 * register index
// Notes:   Rule summary below
package nvmsda_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [5:0] IDX_LOCKS      = 6'h01;
  localparam logic [5:0] IDX_STATUS     = 6'h02;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h03;
  localparam logic [5:0] IDX_IRQ_FLAGS  = 6'h04;
  localparam logic [5:0] IDX_DATA_LO    = 6'h06;
  localparam logic [5:0] IDX_DATA_HI    = 6'h07;
  localparam logic [5:0] IDX_ADDR_LO    = 6'h08;
  localparam logic [5:0] IDX_ADDR_MID   = 6'h09;
  localparam logic [5:0] IDX_ADDR_EXT   = 6'h0A;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int POS_CODE_LOCK  = 0;
  localparam int POS_DATA_LOCK  = 2;
  localparam int POS_FLASH_BUSY = 0;
  localparam int POS_EE_BUSY    = 1;
  localparam int POS_ERR_LO     = 4;
  localparam int POS_IDLE_FLAG  = 0;

  // ==========================================================================
  // Reset values and widths
  // ==========================================================================
  localparam logic [2:0]  RST_ERR       = 3'h0;
  localparam logic [15:0] RST_DATA      = 16'h0000;
  localparam logic [23:0] RST_ADDR      = 24'h000000;
  localparam int          EE_ADDR_BITS  = 8;
  localparam int          FL_ADDR_BITS  = 16;
  localparam int          AXI_AW        = 8;

  // ==========================================================================
  // Error codes and command codes
  // ==========================================================================
  localparam logic [2:0] ERR_NONE        = 3'h0;
  localparam logic [2:0] ERR_UNSUPPORTED = 3'h1;
  localparam logic [2:0] ERR_PROTECTED   = 3'h2;
  localparam logic [2:0] ERR_OVERLAP     = 3'h3;
  localparam logic [6:0] CMD_IDLE        = 7'h00;
  localparam logic [6:0] CMD_NO_OP       = 7'h01;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // Read channel state, one bit, Gray trivially
  typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_RESP = 1'b1} nvmsda_rd_e;

  // One completed array access reported by the controller
  typedef struct packed {
    logic        valid;
    logic        is_eeprom;
    logic [23:0] addr;
    logic [15:0] data;
  } nvmsda_access_s;

  // One section update request from the controller
  typedef struct packed {
    logic valid;
    logic data_section;
  } nvmsda_update_s;

endpackage

//--- hw/nvmsda_sync3.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input may change at any time relative to the clock
// Notes:   Output follows only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module nvmsda_sync3
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Data
  input  wire logic din,
  output var  logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ==========================================================================
  // Shift chain; the first stage feeds only the second
  // ==========================================================================
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout <= s3_r; // Filter out a single-cycle disagreement
    end
  end
endmodule // nvmsda_sync3
`default_nettype wire

//--- hw/nvmsda_regs.sv
// Purpose: Status, interrupt, data and address registers of the nonvolatile controller
// Assumes: AXI4-Lite slave, single clock REF_CLK, busy levels arrive asynchronously
// Notes:   Hardware events win over software clears in the same cycle
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module nvmsda_regs
(
  // Clock and reset
  input  wire logic                    REF_CLK,
  input  wire logic                    RST,
  // AXI4-Lite write address and data
  input  wire logic                    S_AXI_AWVALID,
  output var  logic                    S_AXI_AWREADY,
  input  wire logic [7:0]              S_AXI_AWADDR,
  input  wire logic                    S_AXI_WVALID,
  output var  logic                    S_AXI_WREADY,
  input  wire logic [31:0]             S_AXI_WDATA,
  input  wire logic [3:0]              S_AXI_WSTRB,
  // AXI4-Lite write response
  output var  logic                    S_AXI_BVALID,
  input  wire logic                    S_AXI_BREADY,
  output var  logic [1:0]              S_AXI_BRESP,
  // AXI4-Lite read
  input  wire logic                    S_AXI_ARVALID,
  output var  logic                    S_AXI_ARREADY,
  input  wire logic [7:0]              S_AXI_ARADDR,
  output var  logic                    S_AXI_RVALID,
  input  wire logic                    S_AXI_RREADY,
  output var  logic [31:0]             S_AXI_RDATA,
  output var  logic [1:0]              S_AXI_RRESP,
  // Array side status
  input  wire logic                    FLASH_BUSY,
  input  wire logic                    EEPROM_BUSY,
  // Command events from the controller
  input  wire logic                    CMD_STROBE,
  input  wire logic [6:0]              CMD_CODE,
  input  wire logic                    CMD_UNSUPPORTED,
  input  wire nvmsda_pkg::nvmsda_access_s ACCESS,
  input  wire nvmsda_pkg::nvmsda_update_s UPDATE,
  // Outputs to controller and CPU
  output var  logic                    UPDATE_GRANT,
  output var  logic                    UPDATE_REFUSED,
  output var  logic                    APP_CODE_SECTION_LOCK,
  output var  logic                    APP_DATA_SECTION_LOCK,
  output var  logic                    IRQ
);
  import nvmsda_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic        fl_busy_s;
  logic        ee_busy_s;
  logic [1:0]  busy_raw;
  logic [1:0]  busy_sync;
  logic [2:0]  err_r;
  logic        irq_en_r;
  logic        idle_flag_r;
  logic [15:0] data_r;
  logic [23:0] addr_r;
  logic [7:0]  aw_addr_r;
  logic [7:0]  w_data_r;
  logic        w_lane0_r;
  logic        wr_go;
  logic        wr_ok;
  logic [5:0]  wr_idx;
  logic        irq_en_nxt;
  logic        idle_flag_nxt;
  logic [2:0]  err_nxt;
  logic        collide;
  logic        refuse;
  nvmsda_rd_e  rd_state_r;

  // Map a byte address to a register index; valid only for aligned mapped words
  function automatic logic idx_ok(input logic [7:0] a);
    logic [5:0] i;
    i = a[7:2];
    idx_ok = (a[1:0] == 2'h0) &&
             (i == IDX_LOCKS || i == IDX_STATUS || i == IDX_IRQ_ENABLE ||
              i == IDX_IRQ_FLAGS || i == IDX_DATA_LO || i == IDX_DATA_HI ||
              i == IDX_ADDR_LO || i == IDX_ADDR_MID || i == IDX_ADDR_EXT);
  endfunction

  // Read value of one register; reserved bits come back as zero
  function automatic logic [7:0] reg_read(input logic [5:0] i, input logic [2:0] e,
                                          input logic ie, input logic fl, input logic [15:0] d,
                                          input logic [23:0] ad, input logic [1:0] bz,
                                          input logic [1:0] lk);
    reg_read = 8'h00;
    case (i)
      IDX_LOCKS:      reg_read = {5'h00, lk[1], 1'b0, lk[0]};
      IDX_STATUS:     reg_read = {1'b0, e, 2'h0, bz[1], bz[0]};
      IDX_IRQ_ENABLE: reg_read = {7'h00, ie};
      IDX_IRQ_FLAGS:  reg_read = {7'h00, fl};
      IDX_DATA_LO:    reg_read = d[7:0];
      IDX_DATA_HI:    reg_read = d[15:8];
      IDX_ADDR_LO:    reg_read = ad[7:0];
      IDX_ADDR_MID:   reg_read = ad[15:8];
      IDX_ADDR_EXT:   reg_read = ad[23:16];
      default:        reg_read = 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // Busy inputs come from the array macros and are resynchronised
  // ==========================================================================
  assign busy_raw = {EEPROM_BUSY, FLASH_BUSY};
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_busy_sync
      nvmsda_sync3 u_sync
      (
        .clk  (REF_CLK),
        .rst  (RST),
        .din  (busy_raw[g]),
        .dout (busy_sync[g])
      );
    end
  endgenerate
  assign fl_busy_s = busy_sync[POS_FLASH_BUSY];
  assign ee_busy_s = busy_sync[POS_EE_BUSY];

  // ==========================================================================
  // AXI write channels: address and data taken in either order
  // ==========================================================================
  assign wr_go  = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  assign wr_ok  = idx_ok(aw_addr_r);
  assign wr_idx = aw_addr_r[7:2];

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 8'h00;
      w_lane0_r     <= 1'b0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        S_AXI_AWREADY <= 1'b0;
        aw_addr_r     <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        S_AXI_WREADY <= 1'b0;
        w_data_r     <= S_AXI_WDATA[7:0];  // Only the low byte carries register bits
        w_lane0_r    <= S_AXI_WSTRB[0];
      end
      if (wr_go)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;  // Reopen only after the response is taken
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // AXI read channel: data one cycle after the address is taken
  // ==========================================================================
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      rd_state_r    <= RD_IDLE;
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= RESP_OKAY;
    end
    else
    begin
      case (rd_state_r)
        RD_IDLE:
          if (S_AXI_ARVALID)
          begin
            rd_state_r    <= RD_RESP;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RRESP   <= idx_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            S_AXI_RDATA   <= {24'h000000, idx_ok(S_AXI_ARADDR) ?
                             reg_read(S_AXI_ARADDR[7:2], err_r, irq_en_r, idle_flag_r, data_r,
                                      addr_r, busy_sync,
                                      {APP_DATA_SECTION_LOCK, APP_CODE_SECTION_LOCK}) : 8'h00};
          end
        RD_RESP:
          if (S_AXI_RREADY)
          begin
            rd_state_r    <= RD_IDLE;
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
          end
        default:
          rd_state_r <= RD_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Section locks: set by a write of one, only reset clears them
  // ==========================================================================
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      APP_CODE_SECTION_LOCK <= 1'b0;
      APP_DATA_SECTION_LOCK <= 1'b0;
    end
    else if (wr_go && wr_ok && w_lane0_r && wr_idx == IDX_LOCKS)
    begin
      if (w_data_r[POS_CODE_LOCK])
        APP_CODE_SECTION_LOCK <= 1'b1;
      if (w_data_r[POS_DATA_LOCK])
        APP_DATA_SECTION_LOCK <= 1'b1;
    end
  end

  // ==========================================================================
  // Section update arbitration against the locks
  // ==========================================================================
  assign refuse = UPDATE.data_section ? APP_DATA_SECTION_LOCK
                                      : APP_CODE_SECTION_LOCK;

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      UPDATE_GRANT   <= 1'b0;
      UPDATE_REFUSED <= 1'b0;
    end
    else
    begin
      UPDATE_GRANT   <= UPDATE.valid && !refuse;
      UPDATE_REFUSED <= UPDATE.valid && refuse;
    end
  end

  // ==========================================================================
  // Error field: latest event wins, and any event beats a software write
  // ==========================================================================
  assign collide = CMD_STROBE && CMD_CODE != CMD_IDLE && CMD_CODE != CMD_NO_OP &&
                   (fl_busy_s || ee_busy_s);

  always_comb
  begin
    err_nxt = err_r;
    if (wr_go && wr_ok && w_lane0_r && wr_idx == IDX_STATUS)
      err_nxt = w_data_r[POS_ERR_LO +: 3];
    if (CMD_UNSUPPORTED)
      err_nxt = ERR_UNSUPPORTED;
    if (UPDATE.valid && refuse)
      err_nxt = ERR_PROTECTED;
    if (collide)
      err_nxt = ERR_OVERLAP;
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      err_r <= RST_ERR;
    else
      err_r <= err_nxt;
  end

  // ==========================================================================
  // Interrupt enable, idle flag and level interrupt
  // ==========================================================================
  always_comb
  begin
    irq_en_nxt    = irq_en_r;
    idle_flag_nxt = idle_flag_r;
    if (wr_go && wr_ok && w_lane0_r && wr_idx == IDX_IRQ_ENABLE)
      irq_en_nxt = w_data_r[POS_IDLE_FLAG];
    if (wr_go && wr_ok && w_lane0_r && wr_idx == IDX_IRQ_FLAGS && w_data_r[POS_IDLE_FLAG])
      idle_flag_nxt = 1'b0;
    if (!ee_busy_s)
      idle_flag_nxt = 1'b1;       // Setting wins over the clear
  end

  // Interrupt is computed from next values so a disable drops it at once
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      irq_en_r    <= 1'b0;
      idle_flag_r <= 1'b0;
      IRQ         <= 1'b0;
    end
    else
    begin
      irq_en_r    <= irq_en_nxt;
      idle_flag_r <= idle_flag_nxt;
      IRQ         <= irq_en_nxt && idle_flag_nxt;
    end
  end

  // ==========================================================================
  // Data and address words; a completed access beats a software write
  // ==========================================================================
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      data_r <= RST_DATA;
      addr_r <= RST_ADDR;
    end
    else if (ACCESS.valid)
    begin
      if (ACCESS.is_eeprom)
      begin
        data_r <= {8'h00, ACCESS.data[7:0]};
        addr_r <= {{(24 - EE_ADDR_BITS){1'b0}}, ACCESS.addr[EE_ADDR_BITS-1:0]};
      end
      else
      begin
        data_r <= ACCESS.data;
        addr_r <= {{(24 - FL_ADDR_BITS){1'b0}}, ACCESS.addr[FL_ADDR_BITS-1:0]};
      end
    end
    else if (wr_go && wr_ok && w_lane0_r)
    begin
      case (wr_idx)
        IDX_DATA_LO:  data_r[7:0]   <= w_data_r;
        IDX_DATA_HI:  data_r[15:8]  <= w_data_r;
        IDX_ADDR_LO:  addr_r[7:0]   <= w_data_r;
        IDX_ADDR_MID: addr_r[15:8]  <= w_data_r;
        IDX_ADDR_EXT: addr_r[23:16] <= w_data_r;
        default:      data_r        <= data_r;
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_code_lock_sticky;
    @(posedge REF_CLK) disable iff (RST) APP_CODE_SECTION_LOCK |=> APP_CODE_SECTION_LOCK;
  endproperty
  a_code_lock_sticky: assert property (p_code_lock_sticky) else $error("code lock dropped");

  property p_data_lock_refuse;
    @(posedge REF_CLK) disable iff (RST)
      (UPDATE.valid && UPDATE.data_section && APP_DATA_SECTION_LOCK) |=> UPDATE_REFUSED && !UPDATE_GRANT;
  endproperty
  a_data_lock_refuse: assert property (p_data_lock_refuse) else $error("data update not refused");

  property p_collision_code;
    @(posedge REF_CLK) disable iff (RST) collide |=> err_r == ERR_OVERLAP;
  endproperty
  a_collision_code: assert property (p_collision_code) else $error("collision not recorded");

  property p_protect_code;
    @(posedge REF_CLK) disable iff (RST) (UPDATE.valid && refuse && !collide) |=> err_r == ERR_PROTECTED;
  endproperty
  a_protect_code: assert property (p_protect_code) else $error("protect code wrong");

  property p_err_clear;
    @(posedge REF_CLK) disable iff (RST)
      (wr_go && wr_ok && w_lane0_r && wr_idx == IDX_STATUS && w_data_r[6:4] == 3'h0 &&
       !CMD_UNSUPPORTED && !UPDATE.valid && !collide) |=> err_r == ERR_NONE;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error field not cleared");

  property p_flag_while_idle;
    @(posedge REF_CLK) disable iff (RST) !ee_busy_s |=> idle_flag_r;
  endproperty
  a_flag_while_idle: assert property (p_flag_while_idle) else $error("idle flag not set");

  property p_irq_level;
    @(posedge REF_CLK) disable iff (RST) IRQ == (irq_en_r && idle_flag_r);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

  property p_irq_disable;
    @(posedge REF_CLK) disable iff (RST)
      (wr_go && wr_ok && w_lane0_r && wr_idx == IDX_IRQ_ENABLE && !w_data_r[0]) |=> !IRQ;
  endproperty
  a_irq_disable: assert property (p_irq_disable) else $error("interrupt not dropped");

  property p_ee_data_low;
    @(posedge REF_CLK) disable iff (RST) (ACCESS.valid && ACCESS.is_eeprom) |=> data_r[15:8] == 8'h00;
  endproperty
  a_ee_data_low: assert property (p_ee_data_low) else $error("EEPROM data high byte used");

  property p_ee_addr_mask;
    @(posedge REF_CLK) disable iff (RST)
      (ACCESS.valid && ACCESS.is_eeprom) |=> addr_r == {16'h0000, $past(ACCESS.addr[7:0])};
  endproperty
  a_ee_addr_mask: assert property (p_ee_addr_mask) else $error("address not masked");

  property p_status_read;
    @(posedge REF_CLK) disable iff (RST)
      (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == {IDX_STATUS, 2'h0})
      |=> S_AXI_RDATA[1:0] == $past(busy_sync) && S_AXI_RDATA[7] == 1'b0 && S_AXI_RDATA[3:2] == 2'h0;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  c_collision: cover property (@(posedge REF_CLK) disable iff (RST) collide);
  c_irq_raise: cover property (@(posedge REF_CLK) disable iff (RST) !IRQ ##1 IRQ);
  c_refused:   cover property (@(posedge REF_CLK) disable iff (RST) UPDATE_REFUSED);
  c_ee_access: cover property (@(posedge REF_CLK) disable iff (RST) ACCESS.valid && ACCESS.is_eeprom);

endmodule // nvmsda_regs
`default_nettype wire

//--- test/nvmsda_array_model.sv
// Purpose: Busy-time model of the flash and EEPROM arrays
// Assumes: One start pulse per programming operation
// Notes:   Fixed LEN keeps busy windows predictable for reads
`timescale 1ns/1ps
`default_nettype none
module nvmsda_array_model #(parameter int LEN = 60)
(
  // Clock, reset and starts
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic go_ee,
  input  wire logic go_fl,
  // Busy levels
  output var  logic ee_busy,
  output var  logic fl_busy
);
  logic [7:0] ee_cnt_r;
  logic [7:0] fl_cnt_r;
  // Each array stays busy for a fixed programming time
  always_ff @(posedge clk or posedge rst)
    if (rst) {ee_cnt_r, fl_cnt_r} <= '0;
    else {ee_cnt_r, fl_cnt_r} <= {go_ee ? 8'(LEN) : ee_cnt_r - 8'(ee_cnt_r != 0),
                                  go_fl ? 8'(LEN) : fl_cnt_r - 8'(fl_cnt_r != 0)};
  assign ee_busy = (ee_cnt_r != 0);
  assign fl_busy = (fl_cnt_r != 0);
endmodule // nvmsda_array_model
`default_nettype wire

//--- test/tb_nvmsda_regs.sv
// Purpose: Self-checking bench for the status, data and address registers
// Assumes: Array model drives busy levels; AXI4-Lite master tasks here
// Notes:   Xorshift seed is fixed so runs repeat
`timescale 1ns/1ps
`default_nettype none
module tb_nvmsda_regs;
  import nvmsda_pkg::*;
  logic clk, rst, awv, wv, bry, arv, rry, strb, unsup, go_ee, go_fl, eeb, flb;
  logic awr, wrdy, bv, arr, rv, grant, refused, lk_c, lk_d, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd_d, rdata, seed;
  logic [1:0] bresp, rresp, rd_rsp;
  logic [6:0] code;
  logic [39:0] v;
  nvmsda_access_s acc;
  nvmsda_update_s upd;
  int error_cnt, compares, cyc = 0;
  nvmsda_regs uut(.REF_CLK(clk), .RST(rst), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .FLASH_BUSY(flb),
    .EEPROM_BUSY(eeb), .CMD_STROBE(strb), .CMD_CODE(code), .CMD_UNSUPPORTED(unsup), .ACCESS(acc), .UPDATE(upd),
    .UPDATE_GRANT(grant), .UPDATE_REFUSED(refused), .APP_CODE_SECTION_LOCK(lk_c),
    .APP_DATA_SECTION_LOCK(lk_d), .IRQ(irq));
  nvmsda_array_model #(.LEN(60)) far(.clk(clk), .rst(rst), .go_ee(go_ee), .go_fl(go_fl), .ee_busy(eeb),
    .fl_busy(flb));
  // Expected data and address bytes after one access
  function automatic logic [39:0] expv(input logic e, input logic [23:0] a, input logic [15:0] d);
    expv = e ? {24'(a[EE_ADDR_BITS-1:0]), 8'h00, d[7:0]} : {24'(a[FL_ADDR_BITS-1:0]), d};
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic complete_run();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Each channel is released only at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {awv, wv, bry, awa, wd} <= {3'b111, a, d};
    do
    begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end
    while (bv !== 1'b1);
    bry <= 0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) {arv, rry, ara} <= {2'b11, a};
    do
    begin
      @(posedge clk);
      if (arr) arv <= 0;
    end
    while (rv !== 1'b1);
    rry <= 0;
    {rd_d, rd_rsp} = {rdata, rresp};
    chk(rd_d, e);
  endtask
  task automatic upd_chk(input logic s, input logic e);
    @(posedge clk) upd <= {1'b1, s};
    @(posedge clk) upd <= '0;
    #1 chk(32'({grant, refused}), 32'({!e, e}));
  endtask
  // Clock and hang guard
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  // Main sequence
  initial
  begin
    {awv, wv, bry, arv, rry, strb, unsup, go_ee, go_fl, awa, ara, wd, code, acc, upd} = '0;
    {seed, error_cnt, compares, rst} = {32'h5F4B, 64'h0, 1'b1};
    repeat (12) @(posedge clk);
    rst <= 0;
    repeat (8) @(posedge clk);
    for (int i = 1; i < 11; i++) if (i != 4 && i != 5) rc(8'(4 * i), 0);
    rc(8'h10, 1);
    rc(8'h14, 0);
    chk(32'(rd_rsp), 32'(RESP_SLVERR));
    wr(8'h14, 32'h01);
    chk(32'(bresp), 32'(RESP_SLVERR));
    wr(8'h10, 32'h00);
    chk(32'(bresp), 32'(RESP_OKAY));
    $display("test reset done");
    @(posedge clk) unsup <= 1;
    @(posedge clk) unsup <= 0;
    rc(8'h08, 32'h10);
    wr(8'h08, 32'hFF);
    rc(8'h08, 32'h70);
    wr(8'h08, 0);
    rc(8'h08, 0);
    @(posedge clk) go_fl <= 1;
    @(posedge clk) go_fl <= 0;
    repeat (6) @(posedge clk);
    for (int c = 0; c < 3; c++)
    begin
      @(posedge clk) {strb, code} <= {1'b1, c == 2 ? 7'h02 : 7'(c)};
      @(posedge clk) strb <= 0;
      rc(8'h08, c == 2 ? 32'h31 : 32'h01);
    end
    repeat (70) @(posedge clk);
    wr(8'h08, 0);
    $display("test error done");
    @(posedge clk) go_ee <= 1;
    @(posedge clk) go_ee <= 0;
    repeat (6) @(posedge clk);
    rc(8'h08, 32'h02);
    wr(8'h10, 1);
    rc(8'h10, 0);
    wr(8'h0C, 1);
    #1 chk(32'(irq), 0);
    repeat (70) @(posedge clk);
    #1 chk(32'(irq), 1);
    wr(8'h10, 0);
    rc(8'h10, 1);
    wr(8'h0C, 0);
    @(posedge clk);
    #1 chk(32'(irq), 0);
    $display("test irq done");
    for (int s = 0; s < 2; s++)
    begin
      upd_chk(s[0], 0);
      wr(8'h04, s ? 32'h04 : 32'h01);
      upd_chk(s[0], 1);
      rc(8'h08, 32'h20);
    end
    @(posedge clk) rst <= 1;
    @(posedge clk) rst <= 0;
    @(posedge clk);
    #1 chk(32'({lk_d, lk_c}), 0);
    $display("test lock done");
    repeat (6)
    begin
      for (int k = 0; k < 5; k++)
      begin
        seed = xs(seed);
        wr(8'(24 + 4 * k), {24'h0, seed[7:0]});
        rc(8'(24 + 4 * k), {24'h0, seed[7:0]});
      end
      seed = xs(seed);
      v = expv(seed[31], seed[23:0], seed[15:0] ^ 16'hA5C3);
      @(posedge clk) acc <= {1'b1, seed[31], seed[23:0], seed[15:0] ^ 16'hA5C3};
      @(posedge clk) acc <= '0;
      for (int k = 0; k < 5; k++) rc(8'(24 + 4 * k), 32'(v[8 * k +: 8]));
    end
    $display("test access done");
    complete_run();
  end
endmodule // tb_nvmsda_regs
`default_nettype wire
